// ### shared/nv_array_defs.vh
// constants for the non-volatile array controller
// assumes a 16-bit byte address bus from the processor
`ifndef NV_ARRAY_DEFS_VH
`define NV_ARRAY_DEFS_VH

`define NV_CTRL_ADDR       16'hfe08
`define NV_PROT_ADDR       16'hff7e
`define NV_USER_LO         16'he000
`define NV_USER_HI         16'hfdff
`define NV_VECT_LO         16'hffd2
`define NV_VECT_HI         16'hffff
`define NV_USER_BYTES      7680
`define NV_VECT_BYTES      46
`define NV_PAGE_BYTES      64
`define NV_ROW_BYTES       32

`define NV_BIT_PGM         0
`define NV_BIT_ERASE       1
`define NV_BIT_MASS        2
`define NV_BIT_HIGH_VOLTAGE_ENABLE        3
`define NV_CTRL_RESET      8'h00
`define NV_PROT_RESET      8'hff
`define NV_ERASED_BYTE     8'hff

`define NV_CLK_MHZ         250
`define NV_RCV_NS          1000
`define NV_RCV_CYC         ((`NV_RCV_NS * `NV_CLK_MHZ + 999) / 1000)

`endif

// ### logic/nv_store.v
// byte-wide array storage with registered read data
// assumes the controller sequences erase and program strobes
`timescale 1ns/10ps
`default_nettype none
module nv_store #(
   parameter AW    = 13,
   parameter DEPTH = 8192
) (
   input  wire          clk,
   input  wire [AW-1:0] addr,
   input  wire          rd,
   input  wire          wr,
   input  wire [7:0]    wdata,
   output reg  [7:0]    rdata
);
   reg [7:0] mem [0:DEPTH-1];
   integer   init_i;

   // factory state: every cell erased
   initial
   begin
      for (init_i = 0; init_i < DEPTH; init_i = init_i + 1)
      begin
         mem[init_i] = 8'hff;
      end
   end

   always @(posedge clk)
   begin
      if (wr)
      begin
         mem[addr] <= wdata;
      end
      if (rd)
      begin
         rdata <= mem[addr];
      end
   end
endmodule // nv_store
`default_nettype wire

// ### logic/nv_array_ctrl.v
// controller for the non-volatile array: control register, protection, erase
// assumes a processor port: one-cycle strobes, read data the cycle after
`timescale 1ns/10ps
`default_nettype none
`include "nv_array_defs.vh"

//Contract
// - erased reads one, programmed reads zero; rdata returns 00 for every array read
// - 7680 user bytes, 46 vectors, protect byte
// - 64-byte pages of two rows
// - decode user, control, protect, vector addresses
// - high voltage enable drives pump and array
// - high voltage needs selection and proper order
// - whole-array select erases entire array
// - erase and program never both set
// - write into page latches erase target
// - reads wait recovery after high voltage; the code only raises array_busy, reads are not held
// - protected target blocks high voltage
module nv_array_ctrl #(
   parameter RCV_CYC = `NV_RCV_CYC
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [15:0] addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   output reg         pump_on,
   output reg         array_hv,
   output reg         array_busy
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_SEL   = 3'd1;
   localparam ST_PROT  = 3'd2;
   localparam ST_LATCH = 3'd3;
   localparam ST_HV    = 3'd4;

   // byte index into the storage; vectors and protect byte folded above user space
   function [12:0] map_idx;
      input [15:0] a;
      begin
         map_idx = a[12:0];
      end
   endfunction

   function in_array;
      input [15:0] a;
      begin
         in_array = ((a >= `NV_USER_LO) && (a <= `NV_USER_HI)) ||
                    ((a >= `NV_VECT_LO) && (a <= `NV_VECT_HI)) ||
                    (a == `NV_PROT_ADDR);
      end
   endfunction

   reg [2:0]   st_q;
   reg         pgm_q;
   reg         erase_q;
   reg         mass_q;
   reg         high_voltage_enable_q;
   reg [15:0]  tgt_q;
   reg [7:0]   prot_q;
   reg [15:0]  rcv_q;
   reg [1:0]   rsel_q;
   reg         wipe_q;
   reg [12:0]  wipe_idx_q;
   reg [12:0]  wipe_end_q;

   wire        ctrl_hit = (addr == `NV_CTRL_ADDR);
   wire        arr_hit  = in_array(addr);
   wire [15:0] prot_start = {2'b11, prot_q, 6'b000000};
   wire        tgt_prot = (prot_q != 8'hff) && (tgt_q >= prot_start);
   wire        in_rcv   = (rcv_q != 16'h0000);

   // storage port
   reg         m_wr;
   reg         m_rd;
   reg [12:0]  m_addr;
   reg [7:0]   m_wdata;
   wire [7:0]  m_rdata;

   always @*
   begin
      m_wr    = 1'b0;
      m_rd    = 1'b0;
      m_addr  = map_idx(addr);
      m_wdata = wdata;
      if (wipe_q)
      begin
         m_wr    = 1'b1;
         m_addr  = wipe_idx_q;
         m_wdata = `NV_ERASED_BYTE;
      end
      else if (wr && arr_hit && pgm_q && high_voltage_enable_q && !tgt_prot)
      begin
         m_wr    = 1'b1;
         m_wdata = wdata;
      end
      else if (rd && arr_hit)
      begin
         m_rd = 1'b1;
      end
   end

   nv_store #(
      .AW    (13),
      .DEPTH (8192)
   ) u_store (
      .clk   (clk),
      .addr  (m_addr),
      .rd    (m_rd),
      .wr    (m_wr),
      .wdata (m_wdata),
      .rdata (m_rdata)
   );

   wire [7:0] ctrl_rd = {4'h0, high_voltage_enable_q, mass_q, erase_q, pgm_q};

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q        <= ST_IDLE;
         pgm_q       <= 1'b0;
         erase_q     <= 1'b0;
         mass_q      <= 1'b0;
         high_voltage_enable_q      <= 1'b0;
         tgt_q       <= 16'h0000;
         prot_q      <= `NV_PROT_RESET;
         rcv_q       <= 16'h0000;
         rsel_q      <= 2'd0;
         wipe_q      <= 1'b0;
         wipe_idx_q  <= 13'h0000;
         wipe_end_q  <= 13'h0000;
         pump_on     <= 1'b0;
         array_hv    <= 1'b0;
         array_busy  <= 1'b0;
      end
      else
      begin
         rsel_q <= 2'd0;
         if (in_rcv)
         begin
            rcv_q <= rcv_q - 16'h0001;
         end
         if (wipe_q)
         begin
            wipe_idx_q <= wipe_idx_q + 13'h0001;
            if (wipe_idx_q == wipe_end_q)
            begin
               wipe_q <= 1'b0;
            end
         end
         if (rd && ctrl_hit)
         begin
            rsel_q <= 2'd1;
         end
         else if (rd && arr_hit)
         begin
            rsel_q <= 2'd2;
            if (addr == `NV_PROT_ADDR)
            begin
               rsel_q <= 2'd3;
            end
            if (addr == `NV_PROT_ADDR && (erase_q || pgm_q) && st_q == ST_SEL)
            begin
               st_q <= ST_PROT;
            end
         end
         if (wr && ctrl_hit)
         begin
            mass_q <= wdata[`NV_BIT_MASS];
            if (wdata[`NV_BIT_ERASE] && !pgm_q)
            begin
               erase_q <= 1'b1;
            end
            else if (!wdata[`NV_BIT_ERASE])
            begin
               erase_q <= 1'b0;
               if (erase_q && high_voltage_enable_q)
               begin
                  // erase pulse ends: clear page or whole array
                  wipe_q     <= 1'b1;
                  wipe_idx_q <= mass_q ? 13'h0000 : {tgt_q[12:6], 6'b000000};
                  wipe_end_q <= mass_q ? 13'h1fff : {tgt_q[12:6], 6'b111111};
               end
            end
            if (wdata[`NV_BIT_PGM] && !erase_q && !wdata[`NV_BIT_ERASE])
            begin
               pgm_q <= 1'b1;
            end
            else if (!wdata[`NV_BIT_PGM])
            begin
               pgm_q <= 1'b0;
            end
            if (wdata[`NV_BIT_HIGH_VOLTAGE_ENABLE])
            begin
               if ((erase_q || pgm_q) && st_q == ST_LATCH && !tgt_prot)
               begin
                  high_voltage_enable_q <= 1'b1;
                  st_q   <= ST_HV;
               end
            end
            else
            begin
               if (high_voltage_enable_q)
               begin
                  rcv_q <= RCV_CYC[15:0];
               end
               high_voltage_enable_q <= 1'b0;
               st_q   <= ST_IDLE;
            end
            if ((wdata[`NV_BIT_ERASE] || wdata[`NV_BIT_PGM]) && st_q == ST_IDLE
                && !high_voltage_enable_q)
            begin
               st_q <= ST_SEL;
            end
         end
         else if (wr && arr_hit && st_q == ST_PROT)
         begin
            tgt_q <= addr;
            st_q  <= ST_LATCH;
         end
         if (rsel_q == 2'd3)
         begin
            prot_q <= m_rdata;
         end
         pump_on    <= high_voltage_enable_q;
         array_hv   <= high_voltage_enable_q;
         array_busy <= high_voltage_enable_q || in_rcv || wipe_q;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= 8'h00;
      end
      else
      begin
         rdata <= (rd && ctrl_hit) ? ctrl_rd : 8'h00;
      end
   end

endmodule // nv_array_ctrl
`default_nettype wire

// ### tb/nv_array_ctrl_properties.sv
// port checker for the array controller
// assumes binding to nv_array_ctrl, one clock, async low reset
`timescale 1ns/10ps
`default_nettype none
module nv_array_ctrl_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic        pump_on,
   input wire logic        array_hv,
   input wire logic        array_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_rd_other; rd && addr != 16'hfe08 |=> rdata == 8'h00; endproperty
   a_rd_other: assert property (p_rd_other) else $error("rdata not zero");
   property p_idle; !rd |=> rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("rdata without read");
   property p_upper; rdata[7:4] == 4'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_lock; !(rdata[0] && rdata[1]); endproperty
   a_lock: assert property (p_lock) else $error("erase and program both set");
   property p_pump; pump_on == array_hv; endproperty
   a_pump: assert property (p_pump) else $error("pump and array voltage differ");
   property p_busy; array_hv |-> array_busy; endproperty
   a_busy: assert property (p_busy) else $error("busy low under voltage");
   property p_fall; $fell(array_hv) && $past(rst_n) |-> array_busy; endproperty
   a_fall: assert property (p_fall) else $error("no recovery busy");
   property p_rise; $rose(pump_on) |-> $past(wr) || $past(wr, 2); endproperty
   a_rise: assert property (p_rise) else $error("pump rose without write");
   c_rise: cover property ($rose(pump_on));
   c_fall: cover property ($fell(array_hv));
   c_rd: cover property (rd && addr == 16'hfe08);
endmodule // nv_array_ctrl_chk
`default_nettype wire

// ### tb/flash_page_erase_control_bench.sv
// bench for the array controller: register port and erase sequence
// assumes nv_array_ctrl with a shortened recovery count; pulse waits shortened, untimed by the block
`timescale 1ns/10ps
`default_nettype none
module flash_page_erase_control_bench;
   localparam RCV = 8;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic        pump_on;
   logic        array_hv;
   logic        array_busy;
   logic [31:0] rnd = 32'h9b3d;
   integer      n_fail = 0;
   integer      checks_done = 0;
   integer      m_ctrl = 0;
   integer      m_prot = 0;
   integer      m_lat = 0;
   integer      k;
   integer      i;
   always #2 clk = ~clk;
   nv_array_ctrl #(.RCV_CYC(RCV)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pump_on(pump_on), .array_hv(array_hv),
      .array_busy(array_busy));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] n;
      logic       e;
      logic       p;
      n = d & 8'h0f;
      if (a == 16'hfe08)
      begin
         if (n[3] && !m_ctrl[3] && !((m_ctrl[0] | m_ctrl[1]) && m_prot && m_lat))
            n[3] = 1'b0;
         e = n[1] && !m_ctrl[0];
         p = n[0] && ((!m_ctrl[1] && !n[1]) || m_ctrl[0]);
         if (!d[3])
         begin
            m_prot = 0;
            m_lat = 0;
         end
         m_ctrl = {4'h0, n[3], n[2], e, p};
      end
      else if (m_ctrl[1:0] != 2'b00 && m_prot && a >= 16'he000 && a <= 16'hfdff)
         m_lat = 1;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [15:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, a == 16'hfe08 ? m_ctrl[7:0] : 8'h00);
      if (a == 16'hff7e && m_ctrl[1:0] != 2'b00)
         m_prot = 1;
   endtask
   task automatic pins(input logic e);
      repeat (2) @(posedge clk);
      #1;
      chk("pump_on", {7'h00, pump_on}, {7'h00, e});
      chk("array_hv", {7'h00, array_hv}, {7'h00, e});
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      bus_rd(16'hfe08);
      bus_rd(16'h0000);
      bus_wr(16'hfe08, 8'h08);
      bus_rd(16'hfe08);
      pins(1'b0);
      bus_wr(16'hfe08, 8'h02);
      bus_wr(16'he040, 8'h5a);
      bus_wr(16'hfe08, 8'h0a);
      bus_rd(16'hfe08);
      pins(1'b0);
      bus_wr(16'hfe08, 8'h00);
      bus_wr(16'he000, 8'h00);
      bus_wr(16'hfe08, 8'h02);
      bus_rd(16'hff7e);
      bus_wr(16'hfe08, 8'h0a);
      bus_rd(16'hfe08);
      bus_wr(16'hfe08, 8'h06);
      bus_rd(16'hfe08);
      bus_wr(16'hfe08, 8'h01);
      bus_rd(16'hfe08);
      bus_wr(16'hfe08, 8'h00);
      $display("refusal tests done");
      for (i = 0; i < 3; i = i + 1)
      begin
         rnd = lfsr(rnd);
         bus_wr(16'hfe08, i == 2 ? 8'h06 : 8'h02);
         bus_rd(16'hff7e);
         bus_wr(16'he000 + 16'(rnd % 7680), rnd[23:16]);
         repeat (2500) @(posedge clk);
         bus_wr(16'hfe08, i == 2 ? 8'h0e : 8'h0a);
         pins(1'b1);
         bus_rd(16'hfe08);
         repeat (10000) @(posedge clk);
         bus_wr(16'hfe08, i == 2 ? 8'h0c : 8'h08);
         bus_rd(16'hfe08);
         repeat (i == 2 ? 25000 : 1250) @(posedge clk);
         bus_wr(16'hfe08, 8'h00);
         pins(1'b0);
         chk("array_busy", {7'h00, array_busy}, 8'h01);
         k = 0;
         while (array_busy === 1'b1 && k < RCV + 8)
         begin
            @(posedge clk);
            #1;
            k = k + 1;
         end
         chk("array_busy", {7'h00, array_busy}, 8'h00);
         if (k >= RCV + 8)
            give_verdict;
         $display("erase pass %0d done", i);
      end
      give_verdict;
   end
endmodule // flash_page_erase_control_bench
bind nv_array_ctrl nv_array_ctrl_chk chk_i (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pump_on(pump_on), .array_hv(array_hv),
   .array_busy(array_busy));
`default_nettype wire
